// ===== rtl/med_regs.vh
`ifndef MED_REGS_VH
`define MED_REGS_VH

// Register offsets.
`define MED_ADDR_X_AXIS       8'h00
`define MED_ADDR_Y_AXIS       8'h01
`define MED_ADDR_Z_AXIS       8'h02
`define MED_ADDR_TILT_STATUS  8'h03
`define MED_ADDR_RATE_STATUS  8'h04
`define MED_ADDR_SLEEP_COUNT  8'h05
`define MED_ADDR_IRQ_ENABLES  8'h06
`define MED_ADDR_MODE         8'h07
`define MED_ADDR_RATE_DEB     8'h08
`define MED_ADDR_TAP_THRESH   8'h09
`define MED_ADDR_TAP_DUR      8'h0A

// Reset value of every writable register.
`define MED_RST_BYTE          8'h00

// Interrupt enable bit positions.
`define MED_IE_X_AGIT         7
`define MED_IE_Y_AGIT         6
`define MED_IE_Z_AGIT         5
`define MED_IE_DATA_UPD       4
`define MED_IE_SLEEP_EXP      3
`define MED_IE_TAP            2
`define MED_IE_PORT_LAND      1
`define MED_IE_FACE_SIDE      0

// Mode register bit positions.
`define MED_MODE_ACTIVE       0
`define MED_MODE_TEST         2
`define MED_MODE_AUTO_WAKE    3
`define MED_MODE_AUTO_SLEEP   4

// Rate and debounce register fields.
`define MED_RD_DEBOUNCE       7:5
`define MED_RD_WAKE_RATE      4:3
`define MED_RD_ACTIVE_RATE    2:0

// Tap register fields.
`define MED_TAP_DISABLES      7:5
`define MED_TAP_THRESH        4:0

// Tilt status bit positions and orientation codes.
`define MED_TS_SHAKE          7
`define MED_TS_ALERT          6
`define MED_TS_TAP            5
`define MED_PLANAR_UNKNOWN    3'h0
`define MED_PLANAR_LEFT       3'h1
`define MED_PLANAR_RIGHT      3'h2
`define MED_PLANAR_DOWN       3'h5
`define MED_PLANAR_UP         3'h6
`define MED_FACE_UNKNOWN      2'h0
`define MED_FACE_FRONT        2'h1
`define MED_FACE_BACK         2'h2

// Acceleration limits in output counts.
`define MED_SHAKE_LIMIT       6'h1C
`define MED_FLAT_LIMIT        6'h11
`define MED_FACE_LIMIT        6'h05

// Sample periods in microseconds, clock rate in kHz.
`define MED_CLK_KHZ           25000
`define MED_T_RATE0_US        8360
`define MED_T_RATE1_US        15625
`define MED_T_RATE2_US        31250
`define MED_T_RATE3_US        62500
`define MED_T_RATE4_US        125000
`define MED_T_RATE5_US        250000
`define MED_T_RATE6_US        500000
`define MED_T_RATE7_US        1000000

`endif

// ===== rtl/med_sync.v
`timescale 1ns/1ps
`default_nettype none
module med_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // A change is accepted once the second and third stages agree.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          stage1[i]   <= RST_VAL[i];
          stage2[i]   <= RST_VAL[i];
          stage3[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end
        else
        begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i])
            sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== rtl/med_avg.v
`timescale 1ns/1ps
`default_nettype none
module med_avg (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       reading_valid,
  input  wire [5:0] reading,
  output reg  [5:0] average
);
  reg  [10:0] acc;
  reg  [4:0]  cnt;
  wire [10:0] next_acc = acc + {{5{reading[5]}}, reading};

  // Block average of 32 signed readings; the sum is divided by 32.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc     <= 11'h000;
      cnt     <= 5'h00;
      average <= 6'h00;
    end
    else if (reading_valid)
    begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h1F)
      begin
        average <= next_acc[10:5];
        acc     <= 11'h000;
      end
      else
        acc <= next_acc;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/med_core.v
// Functional notes
// - Interrupt enable register holds individual enables for every event source.
// - Data-update enable raises an interrupt after every new sample.
// - Enabled axis above 1.3 g sets shake and raises an interrupt.
// - Orientation enables raise an interrupt when stored orientation changes.
// - With auto-wake enabled, sleep counter expiry raises an interrupt.
// - In auto-sleep state, shake, tap, delta-G or orientation event wakes.
// - Test mode stops measuring; host-written axis values feed all detectors.
// - No new measurements in standby or test mode.
// - Active mode stores each axis at the selected one of eight rates.
// - Each output sample is the average of 32 readings.
// - Axis registers hold 6-bit values that update the tilt status fields.
// - Debounce zero copies candidate orientation after every reading.
// - Debounce 1 to 7 needs that many matching readings before update.
// - Debounce counter clears on mismatch and on stored update.
// - Z under 0.8g and X larger: up for negative, down for positive X.
// - Z under 0.8g and Y larger: right for negative, left for positive Y.
// - Back below -0.25g Z, front above 0.25g Z.
// - Tap is a change above threshold lasting the duration count.
// - Enabled tap axes are ORed; first detection sets the tap bit.
// - Tap bit suspends tap detection until tilt status is read.
// - All tap disables set gives delta-G detection at any rate.
// - Shake bit clears at the acknowledge of a tilt status read.
`timescale 1ns/1ps
`default_nettype none
`include "med_regs.vh"
module med_core #(
  parameter [6:0] BUS_ADDR  = 7'h2A,
  parameter       RATE0_CYC = `MED_T_RATE0_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE1_CYC = `MED_T_RATE1_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE2_CYC = `MED_T_RATE2_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE3_CYC = `MED_T_RATE3_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE4_CYC = `MED_T_RATE4_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE5_CYC = `MED_T_RATE5_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE6_CYC = `MED_T_RATE6_US * (`MED_CLK_KHZ / 1000),
  parameter       RATE7_CYC = `MED_T_RATE7_US * (`MED_CLK_KHZ / 1000)
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  input  wire       reading_valid,
  input  wire [5:0] reading_x,
  input  wire [5:0] reading_y,
  input  wire [5:0] reading_z,
  output reg        irq
);
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_REG  = 9'h008;
  localparam [8:0] ST_RACK = 9'h010;
  localparam [8:0] ST_WDAT = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RDAT = 9'h080;
  localparam [8:0] ST_MACK = 9'h100;

  function [5:0] mag;
    input [5:0] v;
    begin
      mag = v[5] ? (~v + 6'h01) : v;
    end
  endfunction

  reg  [5:0]  axis [0:2];
  reg  [5:0]  prev_axis [0:2];
  reg  [7:0]  interrupt_enables;
  reg  [7:0]  operating_mode;
  reg  [7:0]  rate_and_debounce;
  reg  [7:0]  tap_threshold_axes;
  reg  [7:0]  tap_duration_count;
  reg  [7:0]  sleep_count;
  reg         shake_flag;
  reg         tap_flag;
  reg         alert_flag;
  reg  [2:0]  planar_position;
  reg  [1:0]  face_side_position;
  reg  [4:0]  cand_prev;
  reg  [2:0]  deb_cnt;
  reg  [7:0]  tap_run;
  reg  [7:0]  sleep_run;
  reg         awake;
  reg         eval;
  reg  [24:0] tick_cnt;
  reg  [8:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shreg;
  reg  [7:0]  out_byte;
  reg  [7:0]  ptr;
  reg         rd_mode;
  reg         mack_ok;
  reg         scl_d;
  reg         sda_d;
  reg  [7:0]  rd_data;
  reg  [31:0] period;

  wire [1:0]  bus_f;
  wire [17:0] avg_bus;
  wire [17:0] reading_bus = {reading_z, reading_y, reading_x};
  wire        scl_f = bus_f[1];
  wire        sda_f = bus_f[0];
  wire        scl_rise = scl_f & ~scl_d;
  wire        scl_fall = ~scl_f & scl_d;
  wire        bus_start = scl_f & scl_d & sda_d & ~sda_f;
  wire        bus_stop = scl_f & scl_d & ~sda_d & sda_f;
  wire        active = operating_mode[`MED_MODE_ACTIVE];
  wire        test_mode = operating_mode[`MED_MODE_TEST];
  wire        measuring = active & ~test_mode;
  wire        tick = measuring & (tick_cnt == period[24:0] - 25'h0000001);
  wire        wr_en = scl_fall & state[5] & (bit_cnt == 4'h8);
  wire        tilt_ack = scl_rise & state[8] & (ptr == `MED_ADDR_TILT_STATUS);
  wire        rd_busy = rd_mode & (state[7] | state[8]);

  med_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({scl_i, sda_i}),
    .sync_out (bus_f)
  );

  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1)
    begin : g_axis
      med_avg u_avg (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .reading_valid (reading_valid & measuring),
        .reading       (reading_bus[6*a+5:6*a]),
        .average       (avg_bus[6*a+5:6*a])
      );
    end
  endgenerate

  always @*
  begin
    case (rate_and_debounce[`MED_RD_ACTIVE_RATE])
      3'h0: period = RATE0_CYC;
      3'h1: period = RATE1_CYC;
      3'h2: period = RATE2_CYC;
      3'h3: period = RATE3_CYC;
      3'h4: period = RATE4_CYC;
      3'h5: period = RATE5_CYC;
      3'h6: period = RATE6_CYC;
      default: period = RATE7_CYC;
    endcase
  end

  always @*
  begin
    case (ptr)
      `MED_ADDR_X_AXIS:      rd_data = {1'b0, alert_flag, axis[0]};
      `MED_ADDR_Y_AXIS:      rd_data = {1'b0, alert_flag, axis[1]};
      `MED_ADDR_Z_AXIS:      rd_data = {1'b0, alert_flag, axis[2]};
      `MED_ADDR_TILT_STATUS: rd_data = {shake_flag, alert_flag, tap_flag, planar_position, face_side_position};
      `MED_ADDR_RATE_STATUS: rd_data = {6'h00, awake, ~awake};
      `MED_ADDR_SLEEP_COUNT: rd_data = sleep_count;
      `MED_ADDR_IRQ_ENABLES: rd_data = interrupt_enables;
      `MED_ADDR_MODE:        rd_data = operating_mode;
      `MED_ADDR_RATE_DEB:    rd_data = rate_and_debounce;
      `MED_ADDR_TAP_THRESH:  rd_data = tap_threshold_axes;
      `MED_ADDR_TAP_DUR:     rd_data = tap_duration_count;
      default:               rd_data = 8'h00;
    endcase
  end

  // Two-wire slave: sample on the rising clock edge, drive data on the falling one.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      out_byte <= 8'h00;
      ptr      <= 8'h00;
      rd_mode  <= 1'b0;
      mack_ok  <= 1'b0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      sda_o    <= 1'b0;
      sda_oe   <= 1'b0;
    end
    else
    begin
      scl_d <= scl_f;
      sda_d <= sda_f;
      if (bus_start)
      begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end
      else if (bus_stop)
      begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state[1] | state[3] | state[5])
        begin
          shreg   <= {shreg[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (state[7])
          bit_cnt <= bit_cnt + 4'h1;
        else if (state[8])
        begin
          mack_ok <= ~sda_f;
          if (~sda_f)
            ptr <= ptr + 8'h01;
        end
      end
      else if (scl_fall)
      begin
        case (state)
          ST_ADDR:
            if (bit_cnt == 4'h8)
            begin
              if (shreg[7:1] == BUS_ADDR)
              begin
                rd_mode <= shreg[0];
                sda_oe  <= 1'b1;
                state   <= ST_AACK;
              end
              else
                state <= ST_IDLE;
            end
          ST_AACK:
          begin
            bit_cnt <= 4'h0;
            if (rd_mode)
            begin
              out_byte <= {rd_data[6:0], 1'b0};
              sda_oe   <= ~rd_data[7];
              state    <= ST_RDAT;
            end
            else
            begin
              sda_oe <= 1'b0;
              state  <= ST_REG;
            end
          end
          ST_REG:
            if (bit_cnt == 4'h8)
            begin
              ptr    <= shreg;
              sda_oe <= 1'b1;
              state  <= ST_RACK;
            end
          ST_RACK, ST_WACK:
          begin
            if (state[6])
              ptr <= ptr + 8'h01;
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_WDAT;
          end
          ST_WDAT:
            if (bit_cnt == 4'h8)
            begin
              sda_oe <= 1'b1;
              state  <= ST_WACK;
            end
          ST_RDAT:
            if (bit_cnt == 4'h8)
            begin
              sda_oe <= 1'b0;
              state  <= ST_MACK;
            end
            else
            begin
              sda_oe   <= ~out_byte[7];
              out_byte <= {out_byte[6:0], 1'b0};
            end
          ST_MACK:
            if (mack_ok)
            begin
              out_byte <= {rd_data[6:0], 1'b0};
              sda_oe   <= ~rd_data[7];
              bit_cnt  <= 4'h0;
              state    <= ST_RDAT;
            end
            else
              state <= ST_IDLE;
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Candidate orientation from the stored axis values.
  wire [5:0] mx = mag(axis[0]);
  wire [5:0] my = mag(axis[1]);
  wire [5:0] mz = mag(axis[2]);
  wire       flat = mz < `MED_FLAT_LIMIT;
  reg  [2:0] cand_planar;
  reg  [1:0] cand_face;
  always @*
  begin
    cand_planar = `MED_PLANAR_UNKNOWN;
    if (flat & (mx > my))
      cand_planar = axis[0][5] ? `MED_PLANAR_UP : `MED_PLANAR_DOWN;
    else if (flat & (my > mx))
      cand_planar = axis[1][5] ? `MED_PLANAR_RIGHT : `MED_PLANAR_LEFT;
    cand_face = `MED_FACE_UNKNOWN;
    if (axis[2][5] & (mz > `MED_FACE_LIMIT))
      cand_face = `MED_FACE_BACK;
    else if (~axis[2][5] & (mz > `MED_FACE_LIMIT))
      cand_face = `MED_FACE_FRONT;
  end

  wire [4:0] cand = {cand_planar, cand_face};
  wire [2:0] deb_len = rate_and_debounce[`MED_RD_DEBOUNCE];
  wire       cand_match = cand == cand_prev;
  wire       orient_upd = eval & ((deb_len == 3'h0) | (cand_match & (deb_cnt + 3'h1 >= deb_len)));
  wire       planar_chg = orient_upd & (cand_planar != planar_position);
  wire       face_chg = orient_upd & (cand_face != face_side_position);
  wire [2:0] shake_hit;
  wire [2:0] tap_hit;
  wire [2:0] tap_dis = tap_threshold_axes[`MED_TAP_DISABLES];
  wire       delta_g = &tap_dis;
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_det
      wire [5:0] diff = axis[k] - prev_axis[k];
      assign shake_hit[k] = interrupt_enables[`MED_IE_X_AGIT - k] & (mag(axis[k]) > `MED_SHAKE_LIMIT);
      assign tap_hit[k] = (delta_g | ~tap_dis[k]) & (mag(diff) > {1'b0, tap_threshold_axes[`MED_TAP_THRESH]});
    end
  endgenerate
  wire tap_allow = (rate_and_debounce[`MED_RD_ACTIVE_RATE] == 3'h0) | delta_g;
  wire tap_on = eval & tap_allow & ~tap_flag & (|tap_hit);
  wire tap_evt = tap_on & (tap_run + 8'h01 >= tap_duration_count);
  wire shake_evt = eval & ~shake_flag & (|shake_hit);
  wire activity = shake_evt | tap_evt | planar_chg | face_chg;
  wire sleep_exp = eval & awake & ~activity & (sleep_run + 8'h01 >= sleep_count);
  wire irq_evt = (eval & interrupt_enables[`MED_IE_DATA_UPD]) | shake_evt
               | (tap_evt & interrupt_enables[`MED_IE_TAP])
               | (planar_chg & interrupt_enables[`MED_IE_PORT_LAND])
               | (face_chg & interrupt_enables[`MED_IE_FACE_SIDE])
               | (sleep_exp & operating_mode[`MED_MODE_AUTO_WAKE] & interrupt_enables[`MED_IE_SLEEP_EXP]);

  integer j;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (j = 0; j < 3; j = j + 1)
      begin
        axis[j]      <= 6'h00;
        prev_axis[j] <= 6'h00;
      end
      interrupt_enables  <= `MED_RST_BYTE;
      operating_mode     <= `MED_RST_BYTE;
      rate_and_debounce  <= `MED_RST_BYTE;
      tap_threshold_axes <= `MED_RST_BYTE;
      tap_duration_count <= `MED_RST_BYTE;
      sleep_count        <= `MED_RST_BYTE;
      shake_flag         <= 1'b0;
      tap_flag           <= 1'b0;
      alert_flag         <= 1'b0;
      planar_position    <= `MED_PLANAR_UNKNOWN;
      face_side_position <= `MED_FACE_UNKNOWN;
      cand_prev          <= 5'h00;
      deb_cnt            <= 3'h0;
      tap_run            <= 8'h00;
      sleep_run          <= 8'h00;
      awake              <= 1'b0;
      eval               <= 1'b0;
      tick_cnt           <= 25'h0000000;
      irq                <= 1'b0;
    end
    else
    begin
      eval <= 1'b0;
      if (~measuring | tick)
        tick_cnt <= 25'h0000000;
      else
        tick_cnt <= tick_cnt + 25'h0000001;
      if (tick)
      begin
        for (j = 0; j < 3; j = j + 1)
          axis[j] <= avg_bus[6*j+:6];
        alert_flag <= rd_busy;
        eval       <= 1'b1;
      end
      if (wr_en)
      begin
        case (ptr)
          `MED_ADDR_X_AXIS, `MED_ADDR_Y_AXIS, `MED_ADDR_Z_AXIS:
            if (test_mode)
            begin
              axis[ptr[1:0]] <= shreg[5:0];
              eval           <= 1'b1;
            end
          `MED_ADDR_SLEEP_COUNT: sleep_count <= shreg;
          `MED_ADDR_IRQ_ENABLES: interrupt_enables <= shreg;
          `MED_ADDR_MODE:        operating_mode <= shreg;
          `MED_ADDR_RATE_DEB:    rate_and_debounce <= shreg;
          `MED_ADDR_TAP_THRESH:  tap_threshold_axes <= shreg;
          `MED_ADDR_TAP_DUR:     tap_duration_count <= shreg;
          default:               ;
        endcase
      end
      if (eval)
      begin
        for (j = 0; j < 3; j = j + 1)
          prev_axis[j] <= axis[j];
        cand_prev <= cand;
        if (~cand_match | orient_upd)
          deb_cnt <= 3'h0;
        else
          deb_cnt <= deb_cnt + 3'h1;
        if (tap_on & ~tap_evt)
          tap_run <= tap_run + 8'h01;
        else
          tap_run <= 8'h00;
        if (activity | sleep_exp | ~awake)
          sleep_run <= 8'h00;
        else
          sleep_run <= sleep_run + 8'h01;
      end
      if (orient_upd)
      begin
        planar_position    <= cand_planar;
        face_side_position <= cand_face;
      end
      if (eval & activity & ~awake & operating_mode[`MED_MODE_AUTO_SLEEP])
        awake <= 1'b1;
      else if (sleep_exp)
        awake <= 1'b0;
      if (shake_evt)
        shake_flag <= 1'b1;
      else if (tilt_ack)
        shake_flag <= 1'b0;
      if (tap_evt)
        tap_flag <= 1'b1;
      else if (tilt_ack)
        tap_flag <= 1'b0;
      if (irq_evt)
        irq <= 1'b1;
      else if (tilt_ack)
        irq <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== test/med_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module med_host_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  logic [7:0] q;
  logic       ok;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves early in the low phase so the device never sees it change while the clock is high.
  task automatic bit_io(input logic b, output logic s);
    #40 sda_pull = !b;
    #160 scl = 1'b1;
    #60 s = sda;
    #60 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic nak, input logic chk);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(nak, a);
    ok = ok & !(chk & a);
  endtask
  task automatic start;
    #40 sda_pull = 1'b0;
    #160 scl = 1'b1;
    #160 sda_pull = 1'b1;
    #160 scl = 1'b0;
  endtask
  task automatic stop;
    #40 sda_pull = 1'b1;
    #160 scl = 1'b1;
    #160 sda_pull = 1'b0;
    #160;
  endtask
  // Callers keep the device in standby before configuring it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ok = 1'b1;
    start;
    xfer({ADDR, 1'b0}, 1'b1, 1'b1);
    xfer(a, 1'b1, 1'b1);
    xfer(d, 1'b1, 1'b1);
    stop;
  endtask
  // Reads two bytes so that the first one is acknowledged.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    ok = 1'b1;
    start;
    xfer({ADDR, 1'b0}, 1'b1, 1'b1);
    xfer(a, 1'b1, 1'b1);
    start;
    xfer({ADDR, 1'b1}, 1'b1, 1'b1);
    xfer(8'hFF, 1'b0, 1'b0);
    d = q;
    xfer(8'hFF, 1'b1, 1'b0);
    stop;
  endtask
endmodule
`default_nettype wire

// ===== test/med_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module med_core_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_OPEN_DRAIN: assert property (!sda_o)
    else $error("data pin output not low");
  AST_IRQ_QUIET_AFTER_RESET: assert property ($fell(sys_rst) |-> !irq [*8])
    else $error("interrupt raised right after reset");
  AST_ACK_STANDS: assert property ($rose(sda_oe) |=> sda_oe [*2])
    else $error("data pin drive too short");
  AST_OE_CHANGES_SCL_LOW: assert property ($changed(sda_oe) |-> !$past(scl_i, 2))
    else $error("data pin drive changed while clock high");
  AST_OE_RELEASE_BOUND: assert property ($rose(sda_oe) |-> ##[2:100] !sda_oe)
    else $error("data pin held too long");
  AST_IDLE_RELEASED: assert property (scl_i [*8] |-> !sda_oe)
    else $error("data pin driven on idle bus");
  AST_IRQ_CLEAR_IN_ACK: assert property ($fell(irq) |-> !$past(sda_i, 3) && $past(scl_i, 3))
    else $error("interrupt cleared outside host ack");
  AST_IRQ_HELD: assert property (irq && $past(sda_i, 2) |=> irq)
    else $error("interrupt dropped without host ack");
endmodule
bind med_core med_core_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// ===== test/tb_motion_event_detector.sv
`timescale 1ns/1ps
`default_nettype none
module tb_motion_event_detector;
  logic              clk;
  logic              sys_rst;
  logic              reading_valid;
  logic        [5:0] rx;
  logic        [5:0] ry;
  logic        [5:0] rz;
  logic signed [5:0] fa;
  logic signed [5:0] fb;
  logic              ph;
  logic        [1:0] pcnt;
  logic              scl;
  logic              sda_pull;
  logic              sda_o;
  logic              sda_oe;
  logic              irq;
  wire               sda;
  logic        [7:0] lfsr;
  logic        [7:0] v;
  logic signed [5:0] vv [0:2];
  int                n_errors;
  int                samples_checked;
  assign sda = !(sda_pull | sda_oe);
  med_core #(
    .RATE0_CYC (200)
  ) dut (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .scl_i         (scl),
    .sda_i         (sda),
    .sda_o         (sda_o),
    .sda_oe        (sda_oe),
    .reading_valid (reading_valid),
    .reading_x     (rx),
    .reading_y     (ry),
    .reading_z     (rz),
    .irq           (irq)
  );
  med_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  // Front end gives a reading every fourth cycle, x alternating between two values.
  always @(posedge clk)
  begin
    #1;
    pcnt = pcnt + 2'd1;
    reading_valid = (pcnt == 2'd0);
    if (reading_valid)
    begin
      ph = !ph;
      rx = ph ? fa : fb;
      ry = fa;
      rz = fb;
    end
  end
  function automatic int rnd(input int lim);
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return int'(lfsr) % (2 * lim + 1) - lim;
  endfunction
  function automatic logic [7:0] orient(input logic signed [5:0] x, input logic signed [5:0] y,
                                        input logic signed [5:0] z);
    int ax;
    int ay;
    int az;
    logic [2:0] p;
    ax = (x < 0) ? -int'(x) : int'(x);
    ay = (y < 0) ? -int'(y) : int'(y);
    az = (z < 0) ? -int'(z) : int'(z);
    p = (az >= 17) ? 3'h0 : (ax > ay) ? ((x < 0) ? 3'h6 : 3'h5) : ((y < 0) ? 3'h2 : 3'h1);
    return {3'h0, p, (z > 5) ? 2'h1 : (z < -5) ? 2'h2 : 2'h0};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] got;
    host.rd(a, got);
    chk(got & m, e);
    chk({7'h00, host.ok}, 8'h01);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #(60000 * 40);
    n_errors++;
    end_of_test;
  end
  initial
  begin
    sys_rst = 1'b1;
    lfsr = 8'h12;
    n_errors = 0;
    samples_checked = 0;
    pcnt = 2'd0;
    ph = 1'b0;
    reading_valid = 1'b0;
    rx = 6'h00;
    ry = 6'h00;
    rz = 6'h00;
    fa = 6'(rnd(28));
    fb = 6'(rnd(28));
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 12; i++)
      if (i != 4)
        rchk((i == 11) ? 8'h1F : 8'(i), 8'hFF, 8'h00);
    for (int i = 3; i < 11; i++)
      if (i != 4 && i != 7)
      begin
        v = 8'(rnd(127));
        host.wr(8'(i), v);
        rchk(8'(i), 8'hFF, (i == 3) ? 8'h00 : v);
      end
    $display("test registers done");
    host.wr(8'h06, 8'h00);
    host.wr(8'h08, 8'h00);
    host.wr(8'h09, 8'hFF);
    host.wr(8'h07, 8'h04);
    for (int n = 0; n < 6; n++)
    begin
      vv[0] = 6'(rnd(28));
      vv[1] = 6'(rnd(28));
      vv[2] = 6'(rnd(16));
      if (vv[0] == vv[1] || vv[0] == -vv[1])
        vv[0] = vv[0] ^ 6'h01;
      for (int a = 0; a < 3; a++)
        host.wr(8'(a), {2'b00, vv[a]});
      for (int a = 0; a < 3; a++)
        rchk(8'(a), 8'hFF, {2'b00, vv[a]});
      rchk(8'h03, 8'h1F, orient(vv[0], vv[1], vv[2]));
    end
    $display("test orientation done");
    host.wr(8'h00, 8'h2C);
    host.wr(8'h01, 8'h00);
    host.wr(8'h02, 8'h0A);
    rchk(8'h03, 8'h1F, 8'h19);
    host.wr(8'h06, 8'h10);
    host.wr(8'h00, 8'h2C);
    chk({7'h00, irq}, 8'h01);
    rchk(8'h03, 8'h1F, 8'h19);
    chk({7'h00, irq}, 8'h00);
    host.wr(8'h06, 8'h01);
    host.wr(8'h00, 8'h14);
    chk({7'h00, irq}, 8'h00);
    host.wr(8'h02, 8'h36);
    chk({7'h00, irq}, 8'h01);
    rchk(8'h03, 8'h1F, 8'h16);
    host.wr(8'h06, 8'h80);
    host.wr(8'h01, 8'h1E);
    chk({7'h00, irq}, 8'h00);
    host.wr(8'h00, 8'h1E);
    chk({7'h00, irq}, 8'h01);
    rchk(8'h03, 8'h80, 8'h80);
    rchk(8'h03, 8'h80, 8'h00);
    $display("test interrupts done");
    host.wr(8'h06, 8'h00);
    host.wr(8'h00, 8'h2C);
    host.wr(8'h01, 8'h00);
    host.wr(8'h02, 8'h0A);
    host.wr(8'h08, 8'h60);
    for (int k = 0; k < 7; k++)
    begin
      host.wr(8'h00, (k == 2) ? 8'h2C : 8'h14);
      rchk(8'h03, 8'h1C, (k == 6) ? 8'h14 : 8'h18);
    end
    $display("test debounce done");
    host.wr(8'h08, 8'h00);
    fa = -6'sd20;
    fb = -6'sd8;
    host.wr(8'h07, 8'h01);
    repeat (900) @(posedge clk);
    #1;
    rchk(8'h00, 8'h3F, 8'h32);
    chk(host.q & 8'h3F, 8'h2C);
    rchk(8'h01, 8'h3F, 8'h2C);
    rchk(8'h02, 8'h3F, 8'h38);
    rchk(8'h03, 8'h1F, 8'h0A);
    $display("test measurement done");
    host.wr(8'h07, 8'h04);
    host.wr(8'h06, 8'h04);
    host.wr(8'h09, 8'hC5);
    host.wr(8'h0A, 8'h02);
    host.wr(8'h01, 8'h0E);
    host.wr(8'h00, 8'h00);
    chk({7'h00, irq}, 8'h00);
    host.wr(8'h00, 8'h0E);
    chk({7'h00, irq}, 8'h01);
    host.wr(8'h00, 8'h00);
    rchk(8'h03, 8'h20, 8'h20);
    host.wr(8'h08, 8'h01);
    host.wr(8'h09, 8'hE5);
    host.wr(8'h00, 8'h0E);
    host.wr(8'h00, 8'h00);
    rchk(8'h03, 8'h20, 8'h20);
    $display("test tap done");
    end_of_test;
  end
endmodule
`default_nettype wire
